// ### logic/pll_clock_cfg_pkg.sv
package pll_clock_cfg_pkg;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] ADDR_RESET_ID_LOW = 8'h00;
   localparam logic [7:0] ADDR_ID_HIGH = 8'h01;
   localparam logic [7:0] ADDR_REVISION = 8'h02;
   localparam logic [7:0] ADDR_FRAC_LOW = 8'h03;
   localparam logic [7:0] ADDR_FRAC_MID = 8'h04;
   localparam logic [7:0] ADDR_FRAC_HIGH = 8'h05;
   localparam logic [7:0] ADDR_INT_RATIO = 8'h06;
   localparam logic [7:0] ADDR_DIV_MODE = 8'h07;
   localparam logic [7:0] ADDR_CLK_SOURCE = 8'h08;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] RST_FRAC_LOW = 8'h21;
   localparam logic [7:0] RST_FRAC_MID = 8'hFD;
   localparam logic [5:0] RST_FRAC_HIGH = 6'h36;
   localparam logic [7:0] RST_INT_RATIO = 8'h07;
   localparam logic [7:0] RST_DIV_MODE = 8'h16;
   localparam logic [7:0] RST_CLK_SOURCE = 8'h18;

   // ----------------------------------------
   // Field positions and widths
   // ----------------------------------------
   localparam int INT_W = 4;
   localparam int FRAC_W = 22;
   localparam int RATIO_W = 26;
   localparam int INPUT_HALVER_BIT = 4;
   localparam int TX_VALID_SUB0_BIT = 5;
   localparam int TX_VALID_SUB1_BIT = 6;
   localparam int TX_VALID_FORCE_BIT = 7;
   localparam int POST_DIV_LSB = 0;
   localparam int FRAC_EN_BIT = 2;
   localparam int MCLK_DIV_BIT = 3;
   localparam int AUX_DIV_LSB = 4;
   localparam int MCLK_SRC_BIT = 7;
   localparam int AUX_SRC_BIT = 3;

   // ----------------------------------------
   // Identity defaults (values are arbitrary)
   // ----------------------------------------
   localparam logic [7:0] DEF_ID_LOW = 8'h3C;
   localparam logic [7:0] DEF_ID_HIGH = 8'hA5;
   localparam logic [3:0] DEF_REVISION = 4'h1;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic [RATIO_W-1:0] ratio;
      logic input_halver;
      logic [1:0] post_divider_sel;
      logic fractional_enable;
      logic master_clock_divide;
      logic [1:0] aux_clock_divide;
      logic master_clock_source;
      logic aux_pin_source;
   } clk_cfg_t;

endpackage

// ### logic/pll_clock_config_regs.sv
`timescale 1ns/1ps
module pll_clock_config_regs #(
   parameter logic [7:0] ID_LOW = pll_clock_cfg_pkg::DEF_ID_LOW,
   parameter logic [7:0] ID_HIGH = pll_clock_cfg_pkg::DEF_ID_HIGH,
   parameter logic [3:0] REVISION = pll_clock_cfg_pkg::DEF_REVISION
) (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire pll_clock_cfg_pkg::reg_req_t req_i,
   input wire logic rx_mode_i,
   input wire logic [1:0] rx_post_div_i,
   input wire logic tx_from_rx_i,
   input wire logic rx_valid_sub0_i,
   input wire logic rx_valid_sub1_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   output logic device_reset_o,
   output pll_clock_cfg_pkg::clk_cfg_t cfg_o,
   output logic tx_valid_sub0_o,
   output logic tx_valid_sub1_o
);
   import pll_clock_cfg_pkg::*;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   logic soft_wr;
   assign soft_wr = req_i.wr && (req_i.addr == ADDR_RESET_ID_LOW);

   // ----------------------------------------
   // Soft reset pulse
   // ----------------------------------------
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         device_reset_o <= 1'b0;
      end
      else
      begin
         device_reset_o <= soft_wr;
      end
   end

   // ----------------------------------------
   // Writable registers
   // ----------------------------------------
   logic [FRAC_W-1:0] frac_q;
   logic [7:0] int_ratio_q;
   logic [7:0] div_mode_q;
   logic [7:0] clk_source_q;

   // A soft reset restores every field, so the write data is never stored
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         frac_q <= {RST_FRAC_HIGH, RST_FRAC_MID, RST_FRAC_LOW};
         int_ratio_q <= RST_INT_RATIO;
         clk_source_q <= RST_CLK_SOURCE;
      end
      else if (soft_wr)
      begin
         frac_q <= {RST_FRAC_HIGH, RST_FRAC_MID, RST_FRAC_LOW};
         int_ratio_q <= RST_INT_RATIO;
         clk_source_q <= RST_CLK_SOURCE;
      end
      else if (req_i.wr)
      begin
         unique case (req_i.addr)
            ADDR_FRAC_LOW: frac_q[7:0] <= req_i.wdata;
            ADDR_FRAC_MID: frac_q[15:8] <= req_i.wdata;
            ADDR_FRAC_HIGH: frac_q[21:16] <= req_i.wdata[5:0];
            ADDR_INT_RATIO: int_ratio_q <= req_i.wdata;
            ADDR_CLK_SOURCE: clk_source_q <= req_i.wdata;
            default: ;
         endcase
      end
   end

   // Receiver-driven post divider wins over a divider mode write in the same cycle, not over a soft reset
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         div_mode_q <= RST_DIV_MODE;
      end
      else if (soft_wr)
      begin
         div_mode_q <= RST_DIV_MODE;
      end
      else
      begin
         if (req_i.wr && (req_i.addr == ADDR_DIV_MODE))
         begin
            div_mode_q <= {2'b00, req_i.wdata[5:0]};
         end
         if (rx_mode_i)
         begin
            div_mode_q[POST_DIV_LSB +: 2] <= rx_post_div_i;
         end
      end
   end

   // ----------------------------------------
   // Read back
   // ----------------------------------------
   // Configuration registers are write-only; reads of them return zero
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         reg_rdata_o <= 8'h00;
         reg_rvalid_o <= 1'b0;
      end
      else
      begin
         reg_rvalid_o <= req_i.rd;
         if (req_i.rd)
         begin
            unique case (req_i.addr)
               ADDR_RESET_ID_LOW: reg_rdata_o <= ID_LOW;
               ADDR_ID_HIGH: reg_rdata_o <= ID_HIGH;
               ADDR_REVISION: reg_rdata_o <= {4'h0, REVISION};
               default: reg_rdata_o <= 8'h00;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Clock configuration outputs
   // ----------------------------------------
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         cfg_o <= '0;
      end
      else
      begin
         cfg_o.ratio <= {int_ratio_q[INT_W-1:0],
                         div_mode_q[FRAC_EN_BIT] ? frac_q : {FRAC_W{1'b0}}};
         cfg_o.input_halver <= int_ratio_q[INPUT_HALVER_BIT];
         cfg_o.post_divider_sel <= div_mode_q[POST_DIV_LSB +: 2];
         cfg_o.fractional_enable <= div_mode_q[FRAC_EN_BIT];
         cfg_o.master_clock_divide <= div_mode_q[MCLK_DIV_BIT] && !clk_source_q[MCLK_SRC_BIT];
         cfg_o.aux_clock_divide <= clk_source_q[AUX_SRC_BIT] ? 2'b00 : div_mode_q[AUX_DIV_LSB +: 2];
         cfg_o.master_clock_source <= clk_source_q[MCLK_SRC_BIT];
         cfg_o.aux_pin_source <= clk_source_q[AUX_SRC_BIT];
      end
   end

   // ----------------------------------------
   // Transmit validity
   // ----------------------------------------
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         tx_valid_sub0_o <= 1'b0;
         tx_valid_sub1_o <= 1'b0;
      end
      else if (int_ratio_q[TX_VALID_FORCE_BIT])
      begin
         tx_valid_sub0_o <= int_ratio_q[TX_VALID_SUB0_BIT];
         tx_valid_sub1_o <= int_ratio_q[TX_VALID_SUB1_BIT];
      end
      else
      begin
         tx_valid_sub0_o <= tx_from_rx_i && rx_valid_sub0_i;
         tx_valid_sub1_o <= tx_from_rx_i && rx_valid_sub1_i;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   AST_SOFT_RESET: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      soft_wr |=> device_reset_o ##1
      (cfg_o.post_divider_sel == RST_DIV_MODE[POST_DIV_LSB +: 2] && cfg_o.fractional_enable))
      else $error("Write to offset zero did not reset the device");
   AST_READ_ID_LOW: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (req_i.rd && req_i.addr == ADDR_RESET_ID_LOW) |=> (reg_rvalid_o && reg_rdata_o == ID_LOW))
      else $error("Low identity byte wrong");
   AST_READ_ID_HIGH: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (req_i.rd && req_i.addr == ADDR_ID_HIGH) |=> (reg_rvalid_o && reg_rdata_o == ID_HIGH))
      else $error("High identity byte wrong");
   AST_READ_REV: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (req_i.rd && req_i.addr == ADDR_REVISION) |=> (reg_rdata_o == {4'h0, REVISION}))
      else $error("Revision read wrong");
   AST_READ_BLOCKED: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (req_i.rd && req_i.addr > ADDR_REVISION) |=> (reg_rdata_o == 8'h00))
      else $error("Write-only register returned data");
   AST_FRAC_SPLIT: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (req_i.wr && req_i.addr == ADDR_FRAC_HIGH) |=> (frac_q[21:16] == $past(req_i.wdata[5:0])))
      else $error("Fraction high bits not stored");
   AST_HALVER: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (req_i.wr && req_i.addr == ADDR_INT_RATIO) |=> ##1 (cfg_o.input_halver == $past(req_i.wdata[4], 2)))
      else $error("Input halver did not follow write");
   AST_FORCE_VALID: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      int_ratio_q[TX_VALID_FORCE_BIT] |=> (tx_valid_sub1_o == $past(int_ratio_q[TX_VALID_SUB1_BIT])))
      else $error("Forced validity not sent");
   AST_PASS_VALID: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      !int_ratio_q[TX_VALID_FORCE_BIT] |=> (tx_valid_sub0_o == ($past(tx_from_rx_i) && $past(rx_valid_sub0_i))))
      else $error("Pass-through validity wrong");
   AST_AUTO_POSTDIV: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (rx_mode_i && !soft_wr) |=> ##1 (cfg_o.post_divider_sel == $past(rx_post_div_i, 2)))
      else $error("Post divider not updated in receive mode");
   AST_INT_MODE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      !cfg_o.fractional_enable |-> (cfg_o.ratio[FRAC_W-1:0] == '0))
      else $error("Fraction used in integer mode");
   AST_MCLK_GATE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      cfg_o.master_clock_source |-> !cfg_o.master_clock_divide)
      else $error("Master clock divide active with oscillator source");
   AST_AUX_GATE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      cfg_o.aux_pin_source |-> (cfg_o.aux_clock_divide == 2'b00))
      else $error("Aux divide active with oscillator source");

   // ----------------------------------------
   // Soft reset checks
   // ----------------------------------------
   // The pulse must never appear without a write to offset zero one edge earlier
   AST_RESET_PULSE_SRC: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      device_reset_o |-> $past(soft_wr))
      else $error("Reset pulse without a write to offset zero");
   AST_SOFT_FRAC: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      soft_wr |=> (frac_q == {RST_FRAC_HIGH, RST_FRAC_MID, RST_FRAC_LOW}))
      else $error("Fraction not restored by soft reset");
   AST_SOFT_INT: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      soft_wr |=> (int_ratio_q == RST_INT_RATIO))
      else $error("Integer ratio not restored by soft reset");
   AST_SOFT_SRC: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      soft_wr |=> (clk_source_q == RST_CLK_SOURCE))
      else $error("Clock source not restored by soft reset");
   AST_SOFT_DIV: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      soft_wr |=> (div_mode_q == RST_DIV_MODE))
      else $error("Divider mode not restored by soft reset");

   // ----------------------------------------
   // Read back checks
   // ----------------------------------------
   // Read data holds, so a slow host may still fetch it late
   AST_RVALID_PULSE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      reg_rvalid_o |-> $past(req_i.rd))
      else $error("Read valid without a read");
   AST_RVALID_ON_READ: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      req_i.rd |=> reg_rvalid_o)
      else $error("Read not answered");
   AST_RDATA_HOLD: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      !req_i.rd |=> $stable(reg_rdata_o))
      else $error("Read data changed without a read");
   AST_RO_WRITE_IGNORED: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (req_i.wr && !rx_mode_i && (req_i.addr == ADDR_ID_HIGH || req_i.addr == ADDR_REVISION))
      |=> $stable({frac_q, int_ratio_q, div_mode_q, clk_source_q}))
      else $error("Write to a read-only register changed state");

   // ----------------------------------------
   // Fraction and ratio checks
   // ----------------------------------------
   // Each byte lands on its own; nothing latches the three together
   AST_FRAC_LOW: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (req_i.wr && req_i.addr == ADDR_FRAC_LOW) |=> (frac_q[7:0] == $past(req_i.wdata)))
      else $error("Fraction low bits not stored");
   AST_FRAC_MID: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (req_i.wr && req_i.addr == ADDR_FRAC_MID) |=> (frac_q[15:8] == $past(req_i.wdata)))
      else $error("Fraction middle bits not stored");
   AST_FRAC_KEEP: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      !(req_i.wr && (req_i.addr == ADDR_RESET_ID_LOW || req_i.addr == ADDR_FRAC_LOW
      || req_i.addr == ADDR_FRAC_MID || req_i.addr == ADDR_FRAC_HIGH)) |=> $stable(frac_q))
      else $error("Fraction changed without a write to it");
   AST_RATIO_FRAC: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (req_i.wr && req_i.addr == ADDR_FRAC_HIGH) |=> ##1
      (!cfg_o.fractional_enable || cfg_o.ratio[FRAC_W-1:16] == $past(req_i.wdata[5:0], 2)))
      else $error("Ratio fraction does not follow write");
   AST_RATIO_INT: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (req_i.wr && req_i.addr == ADDR_INT_RATIO) |=> ##1 (cfg_o.ratio[RATIO_W-1:FRAC_W] == $past(req_i.wdata[3:0], 2)))
      else $error("Ratio integer part does not follow write");

   // ----------------------------------------
   // Divider and mode checks
   // ----------------------------------------
   // Receiver and software are the only two writers of the post divider
   // A soft reset is excluded here because it is checked on its own above
   AST_POSTDIV_WRITE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (req_i.wr && req_i.addr == ADDR_DIV_MODE && !rx_mode_i)
      |=> (div_mode_q[POST_DIV_LSB +: 2] == $past(req_i.wdata[1:0])))
      else $error("Post divider write not stored");
   AST_POSTDIV_HOLD: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (!rx_mode_i && !soft_wr && !(req_i.wr && req_i.addr == ADDR_DIV_MODE))
      |=> $stable(div_mode_q))
      else $error("Divider mode changed with no writer");
   AST_RX_WINS: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (rx_mode_i && !soft_wr) |=> (div_mode_q[POST_DIV_LSB +: 2] == $past(rx_post_div_i)))
      else $error("Receiver post divider did not win");
   AST_FRACTIONAL_ENABLE_FOLLOW: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (req_i.wr && req_i.addr == ADDR_DIV_MODE) |=> ##1 (cfg_o.fractional_enable == $past(req_i.wdata[FRAC_EN_BIT], 2)))
      else $error("Fractional enable does not follow write");

   // ----------------------------------------
   // Clock source checks
   // ----------------------------------------
   // The aux divide is checked through the source write and the master divide through the mode write, so both gates see traffic
   AST_MCLK_DIV_USED: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (req_i.wr && req_i.addr == ADDR_DIV_MODE && !clk_source_q[MCLK_SRC_BIT])
      |=> ##1 (cfg_o.master_clock_divide == $past(req_i.wdata[MCLK_DIV_BIT], 2)))
      else $error("Master clock divide not applied");
   AST_AUX_DIV_USED: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (req_i.wr && req_i.addr == ADDR_CLK_SOURCE && !req_i.wdata[AUX_SRC_BIT])
      |=> ##1 (cfg_o.aux_clock_divide == $past(div_mode_q[AUX_DIV_LSB +: 2], 2)))
      else $error("Aux clock divide not applied");
   AST_MCLK_SRC_FOLLOW: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (req_i.wr && req_i.addr == ADDR_CLK_SOURCE) |=> ##1 (cfg_o.master_clock_source == $past(req_i.wdata[MCLK_SRC_BIT], 2)))
      else $error("Master clock source does not follow write");
   AST_AUX_SRC_FOLLOW: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (req_i.wr && req_i.addr == ADDR_CLK_SOURCE) |=> ##1 (cfg_o.aux_pin_source == $past(req_i.wdata[AUX_SRC_BIT], 2)))
      else $error("Aux pin source does not follow write");

   // ----------------------------------------
   // Validity checks
   // ----------------------------------------
   // One cycle from the register or inputs to the pins
   AST_FORCE_SUB0: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      int_ratio_q[TX_VALID_FORCE_BIT] |=> (tx_valid_sub0_o == $past(int_ratio_q[TX_VALID_SUB0_BIT])))
      else $error("Forced validity sub0 not sent");
   AST_PASS_SUB1: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      !int_ratio_q[TX_VALID_FORCE_BIT] |=> (tx_valid_sub1_o == ($past(tx_from_rx_i) && $past(rx_valid_sub1_i))))
      else $error("Pass-through validity sub1 wrong");
   AST_AUDIO_PORT_ZERO: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      (!int_ratio_q[TX_VALID_FORCE_BIT] && !tx_from_rx_i) |=> (!tx_valid_sub0_o && !tx_valid_sub1_o))
      else $error("Validity not zero from audio port");

endmodule

// ### tb/ctrl_host_model.sv
`timescale 1ns/1ps
module ctrl_host_model (
   input wire logic ref_clk_i,
   output pll_clock_cfg_pkg::reg_req_t req_o
);
   import pll_clock_cfg_pkg::*;
   initial req_o = '0;
   // One strobe per access, raised after a falling edge and held across one rising edge
   task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
      @(negedge ref_clk_i);
      req_o.addr = a;
      req_o.wdata = (w && a == ADDR_INT_RATIO && (d[3:0] < 4'h5 || d[3:0] > 4'hD)) ? {d[7:4], 4'h8} : d;
      req_o.wr = w;
      req_o.rd = !w;
      @(negedge ref_clk_i);
      req_o.wr = 1'b0;
      req_o.rd = 1'b0;
      // Released bus shows the inverse, so a stale value cannot pass for a held one
      req_o.addr = ~a;
      req_o.wdata = ~d;
   endtask
endmodule

// ### tb/pll_clock_config_regs_tb.sv
`timescale 1ns/1ps
module pll_clock_config_regs_tb;
   import pll_clock_cfg_pkg::*;
   localparam clk_cfg_t DFLT = '{ratio: {RST_INT_RATIO[INT_W-1:0], RST_FRAC_HIGH, RST_FRAC_MID, RST_FRAC_LOW},
      input_halver: 1'b0, post_divider_sel: 2'b10,
      fractional_enable: 1'b1, master_clock_divide: 1'b0, aux_clock_divide: 2'b00,
      master_clock_source: 1'b0, aux_pin_source: 1'b1};
   logic ref_clk, reset_n, rx_mode, tx_from_rx, rx_v0, rx_v1, rvalid, dev_rst, tv0, tv1;
   logic [1:0] rx_post_div;
   logic [7:0] rdata;
   logic [21:0] k;
   logic [3:0] n;
   logic [7:0] v;
   reg_req_t req;
   clk_cfg_t cfg, exp_cfg;
   logic [7:0] exp_q[$];
   int err_total, samples_checked;
   int seed = 41179;
   pll_clock_config_regs dut (.ref_clk_i(ref_clk), .reset_n_i(reset_n), .req_i(req), .rx_mode_i(rx_mode),
      .rx_post_div_i(rx_post_div), .tx_from_rx_i(tx_from_rx), .rx_valid_sub0_i(rx_v0), .rx_valid_sub1_i(rx_v1),
      .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .device_reset_o(dev_rst), .cfg_o(cfg),
      .tx_valid_sub0_o(tv0), .tx_valid_sub1_o(tv1));
   ctrl_host_model host (.ref_clk_i(ref_clk), .req_o(req));
   // ----------------------------------------
   // Checking
   // ----------------------------------------
   task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.access(a, d, 1'b1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.access(a, 8'h00, 1'b0);
   endtask
   // Configuration shows a write one edge after it was taken
   task automatic cfg_chk();
      repeat (2) @(negedge ref_clk);
      check("cfg", 40'(cfg), 40'(exp_cfg));
   endtask
   // Each read answer takes the oldest note; an answer with no note compares against unknown
   always @(negedge ref_clk)
      if (rvalid === 1'b1)
         check("rdata", 40'(rdata), exp_q.size() > 0 ? 40'(exp_q.pop_front()) : 40'hX);
   // ----------------------------------------
   // Stimulus
   // ----------------------------------------
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial
   begin
      #200000;
      err_total++;
      print_verdict();
   end
   initial
   begin
      reset_n = 1'b0;
      rx_mode = 1'b0;
      rx_post_div = 2'b00;
      tx_from_rx = 1'b0;
      rx_v0 = 1'b0;
      rx_v1 = 1'b0;
      err_total = 0;
      samples_checked = 0;
      exp_cfg = DFLT;
      repeat (16) @(negedge ref_clk);
      reset_n = 1'b1;
      repeat (2) @(negedge ref_clk);
      check("cfg reset", 40'(cfg), 40'(DFLT));
      rd(ADDR_RESET_ID_LOW, DEF_ID_LOW);
      wr(ADDR_ID_HIGH, 8'h00);
      rd(ADDR_ID_HIGH, DEF_ID_HIGH);
      rd(ADDR_REVISION, {4'h0, DEF_REVISION});
      rd(ADDR_FRAC_LOW, 8'h00);
      rd(8'hFF, 8'h00);
      for (int i = 0; i < 3; i++)
      begin
         k = 22'($random(seed));
         n = 4'(5 + ($unsigned($random(seed)) % 9));
         v = 8'($random(seed));
         wr(ADDR_FRAC_LOW, k[7:0]);
         wr(ADDR_FRAC_MID, k[15:8]);
         wr(ADDR_FRAC_HIGH, {v[7:6], k[21:16]});
         wr(ADDR_INT_RATIO, {4'h0, n});
         exp_cfg.ratio = {n, k};
         cfg_chk();
      end
      wr(ADDR_DIV_MODE, 8'h29);
      exp_cfg = '{{n, 22'h0}, 1'b0, 2'b01, 1'b0, 1'b1, 2'b00, 1'b0, 1'b1};
      cfg_chk();
      wr(ADDR_CLK_SOURCE, 8'h00);
      exp_cfg.aux_pin_source = 1'b0;
      exp_cfg.aux_clock_divide = 2'b10;
      cfg_chk();
      wr(ADDR_CLK_SOURCE, 8'h88);
      exp_cfg = '{{n, 22'h0}, 1'b0, 2'b01, 1'b0, 1'b0, 2'b00, 1'b1, 1'b1};
      cfg_chk();
      // Receive mode: prescribed fraction and fractional mode kept on
      wr(ADDR_FRAC_LOW, 8'h21);
      wr(ADDR_FRAC_MID, 8'hFD);
      wr(ADDR_FRAC_HIGH, 8'h36);
      rx_mode = 1'b1;
      rx_post_div = 2'b11;
      wr(ADDR_DIV_MODE, 8'h24);
      exp_cfg = '{{n, RST_FRAC_HIGH, RST_FRAC_MID, RST_FRAC_LOW}, 1'b0, 2'b11, 1'b1, 1'b0, 2'b00, 1'b1, 1'b1};
      cfg_chk();
      rx_mode = 1'b0;
      tx_from_rx = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         rx_v0 = ~i[0];
         rx_v1 = ~i[1];
         wr(ADDR_INT_RATIO, {1'b1, i[1], i[0], 1'b1, n});
         exp_cfg.input_halver = 1'b1;
         cfg_chk();
         check("tx valid", 40'({tv1, tv0}), 40'(i[1:0]));
      end
      wr(ADDR_INT_RATIO, {4'h0, n});
      for (int j = 0; j < 8; j++)
      begin
         tx_from_rx = j[2];
         rx_v0 = j[0];
         rx_v1 = j[1];
         repeat (2) @(negedge ref_clk);
         check("tx valid", 40'({tv1, tv0}), 40'(j[2] ? j[1:0] : 2'b00));
      end
      wr(ADDR_RESET_ID_LOW, 8'($random(seed)));
      check("reset pulse", 40'(dev_rst), 40'h1);
      @(negedge ref_clk);
      check("reset pulse end", 40'(dev_rst), 40'h0);
      check("cfg soft reset", 40'(cfg), 40'(DFLT));
      rd(ADDR_RESET_ID_LOW, DEF_ID_LOW);
      repeat (3) @(negedge ref_clk);
      check("reads pending", 40'(exp_q.size()), 40'h0);
      print_verdict();
   end
endmodule
